// ### hw/fcal_pkg.sv
// Package of the fault consequent action logic: constants, modes and carriers.
// Assumes one 20 MHz clock and byte-wide PCM and satellite overhead streams.
package fcal_pkg;

  // Timing of the single clock.
  localparam int CLK_PERIOD_NS = 50;

  // Byte patterns forced into the streams.
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] MF_ALARM_WORD = 8'h0f;
  localparam logic [7:0] SIG_B_SET = 8'h44;
  localparam logic [7:0] SIG_AB_SET = 8'hcc;

  // Bit 3 of the non-frame-alignment word, counted from the first bit sent.
  localparam int NFAS_ALARM_BIT = 5;

  // Timeslot and frame positions.
  localparam logic [5:0] TS_ALIGN = 6'h00;
  localparam logic [5:0] TS_SIG = 6'h10;
  localparam logic [5:0] TS_SIG_HI = 6'h30;
  localparam logic [3:0] MF_FRAME0 = 4'h0;

  // Fixed signalling choice.
  typedef enum logic [1:0] {
    FIX_NONE = 2'h0,
    FIX_B = 2'h1,
    FIX_AB = 2'h2,
    FIX_ABCD = 2'h3
  } fcal_fix_t;

  // Backup bearer states.
  typedef enum logic [0:0] {
    BRR_LOOP = 1'h0,
    BRR_BACKUP = 1'h1
  } fcal_bearer_t;

  // Fault levels from the detection logic.
  typedef struct packed {
    logic unit_fault;
    logic traffic_fault;
    logic deferred_fault;
    logic ter_input_ais;
    logic ter_frame_loss;
    logic ter_mf_sync_loss;
    logic ter_mf_back_alarm;
    logic rx_cas_back_alarm;
    logic sat_rx_fault;
    logic tx_fault;
  } fcal_fault_t;

  // Consequent actions, one bit each.
  typedef struct packed {
    logic ground_ais_insertion;
    logic ground_frame_far_end_alarm;
    logic ground_signalling_ais;
    logic ground_signalling_forced_pattern;
    logic ground_mf_far_end_alarm;
    logic link_ais_insertion;
    logic link_frame_far_end_alarm;
    logic link_signalling_ais;
    logic link_mf_far_end_alarm;
    logic outdoor_upconverter_mute;
    logic carrier_off_action;
    logic send_flow_hold;
    logic receive_flow_hold;
  } fcal_act_t;

  // User configuration.
  typedef struct packed {
    logic insert_active;
    logic spoof;
    logic ais_detect_en;
    logic generate_bearer;
    logic passback;
    logic indep_2m;
    logic drop_insert;
    logic rx_clk_sat;
    fcal_fix_t fix_mode;
  } fcal_cfg_t;

  // One byte of a framed stream.
  typedef struct packed {
    logic valid;
    logic [3:0] frame;
    logic [5:0] ts;
    logic [7:0] data;
  } fcal_byte_t;

  // Relay drives.
  typedef struct packed {
    logic unit;
    logic traffic;
    logic deferred;
  } fcal_relay_t;

  // Whole state of the action logic.
  typedef struct packed {
    fcal_act_t act;
    fcal_relay_t relay;
    fcal_bearer_t bearer;
    fcal_byte_t ter;
    fcal_byte_t sat;
    logic carrier_on;
    logic cts;
    logic rr;
    logic gen_bearer;
    logic backup;
    logic sat_timing;
  } fcal_state_t;

  // State of the pin synchroniser.
  typedef struct packed {
    logic meta;
    logic stable;
  } fcal_sync_t;

endpackage

// ### hw/fcal_sync.sv
// Two-stage synchroniser for one pin level.
// Assumes the pin is asynchronous to clk_in.
`timescale 1ns/1ns
module fcal_sync (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Level
  input wire logic pin_in,
  output logic level_out
);

  fcal_pkg::fcal_sync_t s_q;
  fcal_pkg::fcal_sync_t s_d;

  // The first stage feeds only the second.
  always_comb begin
    s_d.meta = pin_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_out = s_q.stable;

endmodule

// ### hw/fcal_top.sv
// Fault consequent action logic: relays, stream alarms, carrier and flow lines.
// Assumes fault levels and streams come from logic on clk_in.
// Function
// - Three relays: unit, traffic, deferred.
// - Ground AIS: selected slots in insert, else all.
// - Spoof in insert mode: AIS over whole bearer.
// - Frame far-end alarm sets NFAS bit three.
// - Signalling AIS forces every abcd bit high.
// - Forced pattern: none, b, ab or abcd.
// - Multiframe alarm sends 0000 1111 frame zero.
// - Link AIS ones still framed and scrambled.
// - Link signalling AIS ones in overhead slots.
// - Link multiframe alarm 0000 1111 in overhead.
// - Carrier off while carrier-off action holds.
// - Send flow hold drops clear to send.
// - Receive flow hold drops receiver ready.
// - Multiframe loss: MF alarm only generate/independent.
// - Incoming MF alarm: link frame, spoof multiframe.
// - Receive CAS alarm forwarded only with spoof.
// - Backup bearer only while no bearer seen.
// - Setting disables AIS detection and actions.
// - Link timing downstream needs satellite, and generate only in drop/insert.
`timescale 1ns/1ns
module fcal_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Faults and user settings
  input wire fcal_pkg::fcal_fault_t flt_in,
  input wire fcal_pkg::fcal_cfg_t cfg_in,
  input wire fcal_pkg::fcal_act_t suppress_in,
  input wire logic [31:0] ter_sel_in,
  // Bearer pin
  input wire logic bearer_det_in,
  // Streams
  input wire fcal_pkg::fcal_byte_t ter_in,
  input wire fcal_pkg::fcal_byte_t sat_in,
  output fcal_pkg::fcal_byte_t ter_out,
  output fcal_pkg::fcal_byte_t sat_out,
  // Actions and relays
  output fcal_pkg::fcal_act_t act_out,
  output fcal_pkg::fcal_relay_t relay_out,
  // Line controls
  output logic carrier_on_out,
  output logic cts_out,
  output logic rr_out,
  output logic gen_bearer_out,
  output logic backup_out,
  output logic sat_timing_out
);

  fcal_pkg::fcal_state_t s_q;
  fcal_pkg::fcal_state_t s_d;
  fcal_pkg::fcal_act_t raw;
  logic bearer_seen;
  logic ais_det;
  logic mf_route;
  logic ts_hit;
  logic sat_ovh;
  logic [7:0] tb;
  logic [7:0] sb;

  fcal_sync u_bearer_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .pin_in(bearer_det_in),
    .level_out(bearer_seen)
  );

  always_comb begin
    s_d = s_q;
    raw = '0;
    // Detection of incoming AIS can be switched off.
    ais_det = flt_in.ter_input_ais & cfg_in.ais_detect_en;
    mf_route = cfg_in.generate_bearer | cfg_in.indep_2m;
    raw.ground_ais_insertion = flt_in.sat_rx_fault;
    raw.ground_frame_far_end_alarm = flt_in.sat_rx_fault
      | (flt_in.ter_mf_sync_loss & ~mf_route);
    raw.ground_mf_far_end_alarm = flt_in.ter_mf_sync_loss & mf_route;
    raw.ground_signalling_ais = flt_in.sat_rx_fault;
    raw.ground_signalling_forced_pattern = flt_in.sat_rx_fault
      & (cfg_in.fix_mode != fcal_pkg::FIX_NONE);
    raw.link_ais_insertion = ais_det | flt_in.ter_frame_loss;
    raw.link_frame_far_end_alarm = flt_in.ter_frame_loss
      | (flt_in.ter_mf_back_alarm & ~cfg_in.spoof);
    raw.link_signalling_ais = flt_in.ter_mf_sync_loss;
    raw.link_mf_far_end_alarm = cfg_in.spoof
      & (flt_in.ter_mf_back_alarm | flt_in.rx_cas_back_alarm);
    raw.outdoor_upconverter_mute = flt_in.unit_fault;
    raw.carrier_off_action = flt_in.tx_fault | flt_in.unit_fault;
    raw.send_flow_hold = flt_in.tx_fault;
    raw.receive_flow_hold = flt_in.sat_rx_fault;
    // Actions follow their faults and drop when they clear.
    s_d.act = fcal_pkg::fcal_act_t'(raw & ~suppress_in);

    // Relay drives.
    s_d.relay.unit = flt_in.unit_fault;
    s_d.relay.traffic = flt_in.traffic_fault | ais_det | flt_in.sat_rx_fault;
    s_d.relay.deferred = flt_in.deferred_fault;

    // Line controls.
    s_d.carrier_on = ~s_d.act.carrier_off_action;
    s_d.cts = ~s_d.act.send_flow_hold;
    s_d.rr = ~s_d.act.receive_flow_hold;
    s_d.sat_timing = cfg_in.rx_clk_sat
      & (~cfg_in.drop_insert | cfg_in.generate_bearer);

    // Backup bearer in pass-back mode.
    case (s_q.bearer)
      fcal_pkg::BRR_LOOP: begin
        if (cfg_in.passback && !cfg_in.generate_bearer && !bearer_seen) begin
          s_d.bearer = fcal_pkg::BRR_BACKUP;
        end
      end
      fcal_pkg::BRR_BACKUP: begin
        if (!cfg_in.passback || cfg_in.generate_bearer || bearer_seen) begin
          s_d.bearer = fcal_pkg::BRR_LOOP;
        end
      end
      default: begin
        s_d.bearer = fcal_pkg::BRR_LOOP;
      end
    endcase
    s_d.backup = (s_d.bearer == fcal_pkg::BRR_BACKUP);
    s_d.gen_bearer = cfg_in.generate_bearer | s_d.backup;

    // Outgoing terrestrial multiplex.
    tb = ter_in.data;
    ts_hit = ~cfg_in.insert_active | cfg_in.spoof | ter_sel_in[ter_in.ts[4:0]];
    if (ter_in.ts == fcal_pkg::TS_ALIGN) begin
      if (ter_in.frame[0] && s_d.act.ground_frame_far_end_alarm) begin
        tb[fcal_pkg::NFAS_ALARM_BIT] = 1'b1;
      end
    end else if (ter_in.ts == fcal_pkg::TS_SIG) begin
      if (ter_in.frame == fcal_pkg::MF_FRAME0) begin
        if (s_d.act.ground_mf_far_end_alarm) begin
          tb = fcal_pkg::MF_ALARM_WORD;
        end
      end else if (s_d.act.ground_signalling_ais) begin
        tb = fcal_pkg::ALL_ONES;
      end else if (s_d.act.ground_signalling_forced_pattern) begin
        case (cfg_in.fix_mode)
          fcal_pkg::FIX_B: begin
            tb = tb | fcal_pkg::SIG_B_SET;
          end
          fcal_pkg::FIX_AB: begin
            tb = tb | fcal_pkg::SIG_AB_SET;
          end
          fcal_pkg::FIX_ABCD: begin
            tb = fcal_pkg::ALL_ONES;
          end
          default: begin
            tb = ter_in.data;
          end
        endcase
      end
    end
    if (s_d.act.ground_ais_insertion && ts_hit) begin
      tb = fcal_pkg::ALL_ONES;
    end
    s_d.ter = ter_in;
    s_d.ter.data = tb;

    // Outgoing satellite data and overhead before framing.
    sb = sat_in.data;
    sat_ovh = (sat_in.ts == fcal_pkg::TS_SIG) || (sat_in.ts == fcal_pkg::TS_SIG_HI);
    if (sat_ovh) begin
      if (sat_in.frame == fcal_pkg::MF_FRAME0) begin
        if (s_d.act.link_mf_far_end_alarm) begin
          sb = fcal_pkg::MF_ALARM_WORD;
        end
      end else if (s_d.act.link_signalling_ais) begin
        sb = fcal_pkg::ALL_ONES;
      end
    end else if (s_d.act.link_ais_insertion) begin
      sb = fcal_pkg::ALL_ONES;
    end
    s_d.sat = sat_in;
    s_d.sat.data = sb;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ter_out = s_q.ter;
  assign sat_out = s_q.sat;
  assign act_out = s_q.act;
  assign relay_out = s_q.relay;
  assign carrier_on_out = s_q.carrier_on;
  assign cts_out = s_q.cts;
  assign rr_out = s_q.rr;
  assign gen_bearer_out = s_q.gen_bearer;
  assign backup_out = s_q.backup;
  assign sat_timing_out = s_q.sat_timing;

  // Checks of the action logic.
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  property p_relay;
    flt_in.unit_fault && !flt_in.deferred_fault |=> relay_out.unit && !relay_out.deferred;
  endproperty
  a_relay: assert property (p_relay) else $error("unit relay wrong");

  property p_ais_sel;
    s_d.act.ground_ais_insertion && cfg_in.insert_active && !cfg_in.spoof
      && ter_in.ts > fcal_pkg::TS_SIG && !ter_sel_in[ter_in.ts[4:0]]
      |=> ter_out.data == $past(ter_in.data);
  endproperty
  a_ais_sel: assert property (p_ais_sel) else $error("AIS leaked into slot");

  property p_ais_spoof;
    s_d.act.ground_ais_insertion && cfg_in.spoof |=> ter_out.data == fcal_pkg::ALL_ONES;
  endproperty
  a_ais_spoof: assert property (p_ais_spoof) else $error("spoof AIS missing");

  property p_nfas;
    ter_in.ts == fcal_pkg::TS_ALIGN && ter_in.frame[0] && s_d.act.ground_frame_far_end_alarm
      |=> ter_out.data[fcal_pkg::NFAS_ALARM_BIT];
  endproperty
  a_nfas: assert property (p_nfas) else $error("NFAS alarm bit clear");

  property p_mf_word;
    ter_in.ts == fcal_pkg::TS_SIG && ter_in.frame == fcal_pkg::MF_FRAME0
      && s_d.act.ground_mf_far_end_alarm && !s_d.act.ground_ais_insertion
      |=> ter_out.data == fcal_pkg::MF_ALARM_WORD;
  endproperty
  a_mf_word: assert property (p_mf_word) else $error("MF alarm word wrong");

  property p_sat_ais;
    sat_in.valid && sat_in.ts < fcal_pkg::TS_SIG && s_d.act.link_ais_insertion
      |=> sat_out.data == fcal_pkg::ALL_ONES && sat_out.valid;
  endproperty
  a_sat_ais: assert property (p_sat_ais) else $error("link AIS missing");

  property p_carrier;
    flt_in.tx_fault && !suppress_in.carrier_off_action
      |=> !carrier_on_out && (cts_out == $past(suppress_in.send_flow_hold));
  endproperty
  a_carrier: assert property (p_carrier) else $error("carrier not muted");

  property p_mf_loss;
    flt_in.ter_mf_sync_loss && !cfg_in.generate_bearer && !cfg_in.indep_2m
      |=> !act_out.ground_mf_far_end_alarm;
  endproperty
  a_mf_loss: assert property (p_mf_loss) else $error("MF alarm on looped bearer");

  property p_backup_drop;
    backup_out && bearer_seen |=> !backup_out ##1 (!backup_out || !$past(bearer_seen));
  endproperty
  a_backup_drop: assert property (p_backup_drop) else $error("backup bearer kept");

  property p_clear;
    $fell(flt_in.sat_rx_fault) && !flt_in.tx_fault |=> rr_out;
  endproperty
  a_clear: assert property (p_clear) else $error("action not removed");

  property p_ais_all;
    s_d.act.ground_ais_insertion && !cfg_in.insert_active |=> ter_out.data == fcal_pkg::ALL_ONES;
  endproperty
  a_ais_all: assert property (p_ais_all) else $error("AIS missing outside insert");

  property p_sig_ais;
    ter_in.ts == fcal_pkg::TS_SIG && ter_in.frame != fcal_pkg::MF_FRAME0 && s_d.act.ground_signalling_ais
      |=> ter_out.data == fcal_pkg::ALL_ONES;
  endproperty
  a_sig_ais: assert property (p_sig_ais) else $error("signalling AIS missing");

  property p_fix_b;
    ter_in.ts == fcal_pkg::TS_SIG && ter_in.frame != fcal_pkg::MF_FRAME0
      && s_d.act.ground_signalling_forced_pattern && cfg_in.fix_mode == fcal_pkg::FIX_B
      |=> (ter_out.data & fcal_pkg::SIG_B_SET) == fcal_pkg::SIG_B_SET;
  endproperty
  a_fix_b: assert property (p_fix_b) else $error("b bits not forced");

  property p_fix_ab;
    ter_in.ts == fcal_pkg::TS_SIG && ter_in.frame != fcal_pkg::MF_FRAME0
      && s_d.act.ground_signalling_forced_pattern && cfg_in.fix_mode == fcal_pkg::FIX_AB
      |=> (ter_out.data & fcal_pkg::SIG_AB_SET) == fcal_pkg::SIG_AB_SET;
  endproperty
  a_fix_ab: assert property (p_fix_ab) else $error("ab bits not forced");

  property p_fix_none;
    cfg_in.fix_mode == fcal_pkg::FIX_NONE |=> !act_out.ground_signalling_forced_pattern;
  endproperty
  a_fix_none: assert property (p_fix_none) else $error("pattern forced with no action");

  property p_link_sig;
    (sat_in.ts == fcal_pkg::TS_SIG || sat_in.ts == fcal_pkg::TS_SIG_HI)
      && sat_in.frame != fcal_pkg::MF_FRAME0 && s_d.act.link_signalling_ais |=> sat_out.data == fcal_pkg::ALL_ONES;
  endproperty
  a_link_sig: assert property (p_link_sig) else $error("link signalling AIS missing");

  property p_link_mf;
    (sat_in.ts == fcal_pkg::TS_SIG || sat_in.ts == fcal_pkg::TS_SIG_HI) && sat_in.frame == fcal_pkg::MF_FRAME0
      && s_d.act.link_mf_far_end_alarm |=> sat_out.data == fcal_pkg::MF_ALARM_WORD;
  endproperty
  a_link_mf: assert property (p_link_mf) else $error("link MF alarm word wrong");

  property p_cts;
    flt_in.tx_fault && !suppress_in.send_flow_hold |=> !cts_out && act_out.send_flow_hold;
  endproperty
  a_cts: assert property (p_cts) else $error("clear to send not dropped");

  property p_rr;
    flt_in.sat_rx_fault && !suppress_in.receive_flow_hold |=> !rr_out;
  endproperty
  a_rr: assert property (p_rr) else $error("receiver ready not dropped");

  property p_mf_back_frame;
    flt_in.ter_mf_back_alarm && !cfg_in.spoof && !suppress_in.link_frame_far_end_alarm
      |=> act_out.link_frame_far_end_alarm;
  endproperty
  a_mf_back_frame: assert property (p_mf_back_frame) else $error("link frame alarm missing");

  property p_mf_back_spoof;
    flt_in.ter_mf_back_alarm && cfg_in.spoof && !flt_in.ter_frame_loss && !suppress_in.link_mf_far_end_alarm
      |=> act_out.link_mf_far_end_alarm && !act_out.link_frame_far_end_alarm;
  endproperty
  a_mf_back_spoof: assert property (p_mf_back_spoof) else $error("spoof alarm routing wrong");

  property p_cas_back;
    flt_in.rx_cas_back_alarm && !cfg_in.spoof |=> !act_out.link_mf_far_end_alarm;
  endproperty
  a_cas_back: assert property (p_cas_back) else $error("CAS alarm forwarded without spoof");

  property p_ais_off;
    flt_in.ter_input_ais && !cfg_in.ais_detect_en && !flt_in.ter_frame_loss |=> !act_out.link_ais_insertion;
  endproperty
  a_ais_off: assert property (p_ais_off) else $error("AIS acted on while disabled");

  property p_timing;
    cfg_in.drop_insert && !(cfg_in.generate_bearer && cfg_in.rx_clk_sat) |=> !sat_timing_out;
  endproperty
  a_timing: assert property (p_timing) else $error("link timing passed wrongly");

  property p_backup_set;
    cfg_in.passback && !cfg_in.generate_bearer && !bearer_seen && !backup_out |=> backup_out;
  endproperty
  a_backup_set: assert property (p_backup_set) else $error("backup bearer not started");

  c_backup: cover property (cfg_in.passback && !bearer_seen ##2 backup_out);
  c_spoof_mf: cover property (flt_in.ter_mf_back_alarm && cfg_in.spoof ##1 act_out.link_mf_far_end_alarm);
  c_ais: cover property (ter_in.valid && s_d.act.ground_ais_insertion ##1 ter_out.data == fcal_pkg::ALL_ONES);

endmodule

// ### tb/fcal_far_model.sv
// Far-side model: terrestrial multiplex and satellite framer byte sources, bearer pin.
// Assumes one clock shared with the design; bytes change just after each rising edge.
`timescale 1ns/1ns
module fcal_far_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Bearer presence
  input wire logic bearer_on_in,
  output logic bearer_det_out,
  // Streams
  output fcal_pkg::fcal_byte_t ter_out,
  output fcal_pkg::fcal_byte_t sat_out
);
  logic [9:0] cnt_q;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= cnt_q + 10'h001;
    end
  end
  // Zero payload, so every forced bit shows at the far end.
  assign ter_out = {1'b1, cnt_q[8:5], 1'b0, cnt_q[4:0], 8'h00};
  assign sat_out = {1'b1, cnt_q, 8'h00};
  assign bearer_det_out = bearer_on_in;
endmodule

// ### tb/test_fcal_top.sv
// Bench of the fault consequent action logic: scenario tasks against a reference of the actions.
// Assumes the far-side model feeds both streams and the bearer pin.
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_fcal_top;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic bearer_on = 1'b0;
  logic bearer_det;
  fcal_pkg::fcal_fault_t flt = '0;
  fcal_pkg::fcal_cfg_t cfg = '0;
  fcal_pkg::fcal_act_t sup = '0;
  logic [31:0] sel = 32'h0000_0000;
  fcal_pkg::fcal_fault_t nf;
  fcal_pkg::fcal_cfg_t nc;
  fcal_pkg::fcal_act_t ns;
  logic [31:0] nsel;
  fcal_pkg::fcal_byte_t ter_in, sat_in, ter_out, sat_out;
  fcal_pkg::fcal_act_t act_out;
  fcal_pkg::fcal_relay_t relay_out;
  logic carrier_on_out, cts_out, rr_out, gen_bearer_out, backup_out, sat_timing_out;
  logic [7:0] fx [4] = '{8'h00, 8'h44, 8'hcc, 8'hff};
  int n_fail = 0;
  int checks = 0;

  always #(fcal_pkg::CLK_PERIOD_NS / 2) clk_in = ~clk_in;

  fcal_far_model far (.clk_in(clk_in), .resetn_in(resetn_in), .bearer_on_in(bearer_on),
    .bearer_det_out(bearer_det), .ter_out(ter_in), .sat_out(sat_in));
  fcal_top dut (.clk_in(clk_in), .resetn_in(resetn_in), .flt_in(flt), .cfg_in(cfg), .suppress_in(sup),
    .ter_sel_in(sel), .bearer_det_in(bearer_det), .ter_in(ter_in), .sat_in(sat_in), .ter_out(ter_out),
    .sat_out(sat_out), .act_out(act_out), .relay_out(relay_out), .carrier_on_out(carrier_on_out),
    .cts_out(cts_out), .rr_out(rr_out), .gen_bearer_out(gen_bearer_out), .backup_out(backup_out),
    .sat_timing_out(sat_timing_out));

  function automatic fcal_pkg::fcal_act_t ref_act();
    fcal_pkg::fcal_act_t a;
    logic lp, lf;
    lp = cfg.generate_bearer | cfg.indep_2m;
    lf = flt.ter_frame_loss | (flt.ter_input_ais & cfg.ais_detect_en);
    a.ground_ais_insertion = flt.sat_rx_fault;
    a.ground_frame_far_end_alarm = flt.sat_rx_fault | (flt.ter_mf_sync_loss & ~lp);
    a.ground_signalling_ais = flt.sat_rx_fault;
    a.ground_signalling_forced_pattern = flt.sat_rx_fault;
    a.ground_mf_far_end_alarm = flt.ter_mf_sync_loss & lp;
    a.link_ais_insertion = lf;
    a.link_frame_far_end_alarm = flt.ter_frame_loss | (flt.ter_mf_back_alarm & ~cfg.spoof);
    a.link_signalling_ais = flt.ter_mf_sync_loss;
    a.link_mf_far_end_alarm = (flt.ter_mf_back_alarm | flt.rx_cas_back_alarm) & cfg.spoof;
    a.outdoor_upconverter_mute = flt.unit_fault;
    a.carrier_off_action = flt.unit_fault | flt.tx_fault;
    a.send_flow_hold = flt.tx_fault;
    a.receive_flow_hold = flt.sat_rx_fault;
    return a & ~sup;
  endfunction

  function automatic logic [7:0] ref_ter(fcal_pkg::fcal_byte_t b, fcal_pkg::fcal_act_t a);
    logic [7:0] p;
    p = 8'h00;
    if (b.ts == 6'h00 && b.frame[0] && a.ground_frame_far_end_alarm) begin
      p = 8'h20;
    end
    if (b.ts == 6'h10) begin
      if (b.frame == 4'h0) begin
        p = a.ground_mf_far_end_alarm ? 8'h0f : 8'h00;
      end else if (a.ground_signalling_ais) begin
        p = 8'hff;
      end else if (a.ground_signalling_forced_pattern) begin
        p = fx[cfg.fix_mode];
      end
    end
    if (a.ground_ais_insertion && (!cfg.insert_active || cfg.spoof || sel[b.ts[4:0]])) begin
      p = 8'hff;
    end
    return p;
  endfunction

  function automatic logic [7:0] ref_sat(fcal_pkg::fcal_byte_t b, fcal_pkg::fcal_act_t a);
    if (b.ts == 6'h10 || b.ts == 6'h30) begin
      if (b.frame == 4'h0) begin
        return a.link_mf_far_end_alarm ? 8'h0f : 8'h00;
      end
      return a.link_signalling_ais ? 8'hff : 8'h00;
    end
    return a.link_ais_insertion ? 8'hff : 8'h00;
  endfunction

  task automatic clr();
    nf = '0;
    nc = '0;
    ns = '0;
    nsel = 32'h0000_0000;
  endtask

  task automatic apply();
    @(posedge clk_in);
    flt <= nf;
    cfg <= nc;
    sup <= ns;
    sel <= nsel;
    repeat (2) @(posedge clk_in);
  endtask

  // Applies the next settings, then compares actions, relays, line controls but gen_bearer_out and backup_out, and both streams over a whole satellite multiframe.
  task automatic run();
    fcal_pkg::fcal_act_t e, m;
    fcal_pkg::fcal_relay_t r;
    fcal_pkg::fcal_byte_t tp, sp;
    apply();
    @(negedge clk_in);
    e = ref_act();
    m = '1;
    m.ground_signalling_forced_pattern = (cfg.fix_mode != fcal_pkg::FIX_NONE);
    r.unit = flt.unit_fault;
    r.traffic = flt.traffic_fault | flt.sat_rx_fault | (flt.ter_input_ais & cfg.ais_detect_en);
    r.deferred = flt.deferred_fault;
    `CHK(act_out & m, e & m)
    `CHK(relay_out, r)
    `CHK({carrier_on_out, cts_out, rr_out}, ~{e.carrier_off_action, e.send_flow_hold, e.receive_flow_hold})
    `CHK(sat_timing_out, cfg.rx_clk_sat & (~cfg.drop_insert | cfg.generate_bearer))
    repeat (1024) begin
      tp = ter_in;
      sp = sat_in;
      @(negedge clk_in);
      `CHK(ter_out.data, ref_ter(ter_out, e))
      `CHK(sat_out.data, ref_sat(sat_out, e))
      `CHK(ter_out[18:8], tp[18:8])
      `CHK(sat_out[18:8], sp[18:8])
    end
  endtask

  task automatic s_ground_ais();
    for (int i = 0; i < 3; i++) begin
      clr();
      nf.sat_rx_fault = 1'b1;
      nc.insert_active = (i != 0);
      nc.spoof = (i == 2);
      nc.fix_mode = fcal_pkg::FIX_AB;
      nsel = 32'h0000_0006;
      run();
    end
  endtask

  task automatic s_pattern();
    for (int i = 0; i < 4; i++) begin
      clr();
      nf.sat_rx_fault = 1'b1;
      ns.ground_ais_insertion = 1'b1;
      ns.ground_signalling_ais = 1'b1;
      nc.fix_mode = fcal_pkg::fcal_fix_t'(i[1:0]);
      run();
    end
  endtask

  task automatic s_mf_loss();
    for (int i = 0; i < 3; i++) begin
      clr();
      nf.ter_mf_sync_loss = 1'b1;
      nc.generate_bearer = (i == 0);
      nc.indep_2m = (i == 1);
      run();
    end
  endtask

  task automatic s_back_alarm();
    for (int i = 0; i < 4; i++) begin
      clr();
      nf.ter_mf_back_alarm = i[1];
      nf.rx_cas_back_alarm = !i[1];
      nc.spoof = i[0];
      run();
    end
  endtask

  task automatic s_link_ais();
    for (int i = 0; i < 3; i++) begin
      clr();
      nf.ter_input_ais = (i < 2);
      nf.ter_frame_loss = (i == 2);
      nc.ais_detect_en = i[0];
      run();
    end
  endtask

  task automatic s_lines();
    for (int i = 0; i < 4; i++) begin
      clr();
      nf.unit_fault = i[0];
      nf.tx_fault = !i[0];
      nf.traffic_fault = i[1];
      nf.deferred_fault = !i[1];
      nc.rx_clk_sat = 1'b1;
      nc.drop_insert = 1'b1;
      nc.generate_bearer = i[1];
      run();
    end
  endtask

  task automatic s_bearer();
    clr();
    nc.passback = 1'b1;
    apply();
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    `CHK({backup_out, gen_bearer_out}, 2'h3)
    @(posedge clk_in);
    bearer_on <= 1'b1;
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    `CHK({backup_out, gen_bearer_out}, 2'h0)
    nc.generate_bearer = 1'b1;
    apply();
    @(negedge clk_in);
    `CHK({backup_out, gen_bearer_out}, 2'h1)
  endtask

  // Holds reset for six edges and checks that every action, relay and line output but gen_bearer_out and sat_timing_out is low meanwhile.
  task automatic s_reset();
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    `CHK({act_out, relay_out, carrier_on_out, cts_out, rr_out, backup_out}, 20'h0_0000)
    @(posedge clk_in);
    resetn_in <= 1'b1;
  endtask

  task automatic results();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    s_reset();
    s_ground_ais();
    s_pattern();
    s_mf_loss();
    s_back_alarm();
    s_link_ais();
    s_lines();
    s_bearer();
    results();
  end
endmodule
